// File: bench/mac_model.sv
// MAC-side model: frame report strobes and transmit completion.
// Assumes the block's receive and transmit ports, all on clk_sys.
`timescale 1ns/1ps

module mac_model #(
    parameter int DONE_DLY = 12
) (
    input  wire logic                     clk_sys,
    input  wire logic                     rst_n,
    input  wire logic                     send,
    input  wire rx_tx_pkg::rx_report_type rep,
    input  wire logic                     rx_slot_full,
    input  wire logic                     tx_enqueue_req,
    output logic                          rx_end,
    output rx_tx_pkg::rx_report_type      rx_report,
    output logic                          tx_done
);
    import rx_tx_pkg::*;
    int wait_ff;

    // -----------------------------
    // Receive and transmit sides
    // -----------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_end <= 1'b0;
            rx_report <= '0;
            tx_done <= 1'b0;
            wait_ff <= 0;
        end else begin
            rx_end <= send && !rx_slot_full;
            // Report is stale after the strobe, so invert it every cycle
            rx_report <= (send && !rx_slot_full) ? rep : ~rx_report;
            wait_ff <= tx_enqueue_req ? DONE_DLY : (wait_ff > 0 ? wait_ff - 1 : 0);
            tx_done <= (wait_ff == 1);
        end
    end
endmodule

// File: bench/tb_rx_frame_status_tx_enqueue.sv
// Bench for the receive status and transmit queue block.
// Assumes the MAC model beside it and a 10 MHz system clock.
`timescale 1ns/1ps

module tb_rx_frame_status_tx_enqueue;
    import rx_tx_pkg::*;
    logic          clk_sys, rst_n, bus_wr, bus_rd, send, rx_end, tx_done;
    logic          rx_slot_full, rx_deliver, rx_discard;
    logic          tx_enqueue_req, tx_enqueue_busy, space_event;
    logic [7:0]    bus_addr;
    logic [15:0]   bus_wdata, bus_rdata;
    logic [12:0]   tx_free_bytes;
    rx_report_type rep, rx_report;
    int errors = 0, comparisons = 0, cycles = 0;
    int n_del = 0, n_dis = 0, n_req = 0, n_evt = 0;

    rx_frame_status_tx_enqueue uut (.clk_sys(clk_sys), .rst_n(rst_n),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .rx_end(rx_end), .rx_report(rx_report),
        .rx_slot_full(rx_slot_full), .rx_deliver(rx_deliver), .rx_discard(rx_discard),
        .tx_free_bytes(tx_free_bytes), .tx_done(tx_done), .tx_enqueue_req(tx_enqueue_req),
        .tx_enqueue_busy(tx_enqueue_busy), .space_event(space_event));

    mac_model mac (.clk_sys(clk_sys), .rst_n(rst_n), .send(send), .rep(rep),
        .rx_slot_full(rx_slot_full), .tx_enqueue_req(tx_enqueue_req),
        .rx_end(rx_end), .rx_report(rx_report), .tx_done(tx_done));

    // -----------------------------
    // Clock, pulse counts, timeout
    // -----------------------------
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        if (rx_deliver === 1'b1) n_del++;
        if (rx_discard === 1'b1) n_dis++;
        if (tx_enqueue_req === 1'b1) n_req++;
        if (space_event === 1'b1) n_evt++;
        cycles++;
        if (cycles == 20000) begin
            errors++;
            test_done();
        end
    end

    // -----------------------------
    // Bus tasks and compares
    // -----------------------------
    task automatic test_done;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
    endtask

    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        #1 d = bus_rdata;
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [15:0] e);
        logic [15:0] v;
        rd(a, v);
        chk(nm, e, v);
    endtask

    // Flags: tcp udp bcast mcast ucast sym short fcs
    task automatic do_frame(input logic [7:0] f, input logic [15:0] lt,
                            input logic [11:0] bt, input logic pb);
        logic        drop;
        logic [15:0] e, m, v;
        int          d0;
        int          x0;
        drop = (f[1] | f[0] | (bt > 12'd2000)) & !pb;
        e = {4'h8, f[7:6], 2'h0, f[5], f[5] | f[4], f[3:2],
             lt > 16'd1500, bt > 12'd2000, f[1:0]};
        // Frame type is meaningless for runts
        m = f[1] ? 16'hFFF7 : 16'hFFFF;
        wr(OFS_FRAME_CFG, {15'h0, pb});
        d0 = n_del;
        x0 = n_dis;
        rep <= {f, lt, bt};
        send <= 1'b1;
        @(posedge clk_sys);
        send <= 1'b0;
        for (int i = 0; i < 20 && n_del + n_dis == d0 + x0; i++) @(posedge clk_sys);
        repeat (2) @(posedge clk_sys);
        chk("delivered", {15'h0, !drop}, 16'(n_del - d0));
        chk("discarded", {15'h0, drop}, 16'(n_dis - x0));
        rd(OFS_HDR_STATUS, v);
        if (drop) begin
            chk("hdr_valid", 16'h0000, v & 16'h8000);
        end else begin
            chk("hdr", e & m, v & m);
            rchk("count", OFS_BYTE_COUNT, {4'h0, bt});
        end
        chk("slot", 16'h0000, {15'h0, rx_slot_full});
    endtask

    // -----------------------------
    // Tests
    // -----------------------------
    initial begin
        int r0;
        int e0;
        bus_addr = 8'h00;
        bus_wdata = 16'h0000;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        send = 1'b0;
        rep = '0;
        tx_free_bytes = 13'h0000;
        rst_n = 1'b0;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        rchk("hdr_rst", OFS_HDR_STATUS, 16'h0000);
        rchk("cmd_rst", OFS_TX_CMD, 16'h0000);
        rchk("unmapped", 8'h10, 16'h0000);
        do_frame(8'h80, 16'h0800, 12'd64, 1'b1);
        do_frame(8'h40, 16'h05DC, 12'd2000, 1'b1);
        do_frame(8'h20, 16'h05DD, 12'd2001, 1'b1);
        do_frame(8'h14, 16'h0600, 12'hFFF, 1'b1);
        do_frame(8'h0A, 16'h0800, 12'd40, 1'b1);
        do_frame(8'h01, 16'h0800, 12'd64, 1'b1);
        do_frame(8'h01, 16'h0800, 12'd64, 1'b0);
        do_frame(8'h02, 16'h0800, 12'd40, 1'b0);
        do_frame(8'h00, 16'h0800, 12'd2001, 1'b0);
        r0 = n_req;
        wr(OFS_TX_CMD, 16'h0001);
        rchk("cmd_busy", OFS_TX_CMD, 16'h0001);
        chk("busy", 16'h0001, {15'h0, tx_enqueue_busy});
        wr(OFS_TX_CMD, 16'h0001);
        // host waits for the bit to clear
        for (int i = 0; i < 100 && tx_enqueue_busy !== 1'b0; i++) @(posedge clk_sys);
        chk("req_cnt", 16'h0001, 16'(n_req - r0));
        rchk("cmd_clr", OFS_TX_CMD, 16'h0000);
        chk("busy_clr", 16'h0000, {15'h0, tx_enqueue_busy});
        wr(OFS_TX_CMD, 16'hFFFC);
        rchk("cmd_rsvd", OFS_TX_CMD, 16'h0000);
        wr(OFS_SPACE_REQ, 16'd100);
        rchk("space_req", OFS_SPACE_REQ, 16'd100);
        tx_free_bytes <= 13'd99;
        e0 = n_evt;
        wr(OFS_TX_CMD, 16'h0002);
        repeat (4) @(posedge clk_sys);
        rchk("mon_armed", OFS_TX_CMD, 16'h0002);
        rchk("free", OFS_TX_FREE, 16'd99);
        chk("evt_early", 16'h0000, 16'(n_evt - e0));
        @(posedge clk_sys);
        tx_free_bytes <= 13'd100;
        for (int i = 0; i < 10 && n_evt == e0; i++) @(posedge clk_sys);
        chk("evt", 16'h0001, 16'(n_evt - e0));
        rchk("mon_clr", OFS_TX_CMD, 16'h0000);
        test_done();
    end
endmodule

// File: core/rx_frame_status_tx_enqueue.sv
// Receive frame header status, byte count and transmit queue commands.
// Assumes a MAC that reports each finished frame with a one-cycle strobe.
`timescale 1ns/1ps

module rx_frame_status_tx_enqueue (
    input  wire logic                    clk_sys,
    input  wire logic                    rst_n,
    input  wire logic [7:0]              bus_addr,
    input  wire logic [15:0]             bus_wdata,
    input  wire logic                    bus_wr,
    input  wire logic                    bus_rd,
    output logic [15:0]                  bus_rdata,
    input  wire logic                    rx_end,
    input  wire rx_tx_pkg::rx_report_type rx_report,
    output logic                         rx_slot_full,
    output logic                         rx_deliver,
    output logic                         rx_discard,
    input  wire logic [12:0]             tx_free_bytes,
    input  wire logic                    tx_done,
    output logic                         tx_enqueue_req,
    output logic                         tx_enqueue_busy,
    output logic                         space_event
);
    import rx_tx_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] rdata;
        logic [15:0] hdr;
        logic [11:0] count;
        logic        pass_bad;
        logic        enqueue;
        logic        monitor;
        logic [12:0] space_req;
        logic        enq_pulse;
        logic        space_pulse;
        logic        deliver;
        logic        discard;
    } state_type;

    state_type st_ff;
    state_type nxt_st;

    logic        take;
    logic        oversize;
    logic        bad;
    logic        keep;
    logic [15:0] hdr_new;
    logic        wr_cmd;
    logic        rd_count;

    // ------------------------------------------------------------
    // Frame classification
    // ------------------------------------------------------------
    // One status slot; the MAC must hold its report until the slot frees
    assign take     = rx_end && !st_ff.hdr[BIT_VALID];
    assign oversize = rx_report.byte_total > OVERSIZE_MAX;
    assign bad      = oversize || rx_report.short_frame || rx_report.fcs_bad;
    assign keep     = !bad || st_ff.pass_bad;
    assign wr_cmd   = bus_wr && bus_addr == OFS_TX_CMD;
    assign rd_count = bus_rd && bus_addr == OFS_BYTE_COUNT;

    always_comb begin
        hdr_new = RST_WORD;
        hdr_new[BIT_VALID] = 1'b1;
        hdr_new[BIT_TCP_BAD] = rx_report.tcp_bad;
        hdr_new[BIT_UDP_BAD] = rx_report.udp_bad;
        hdr_new[BIT_BCAST] = rx_report.bcast;
        hdr_new[BIT_MCAST] = rx_report.mcast || rx_report.bcast;
        hdr_new[BIT_UCAST] = rx_report.ucast;
        hdr_new[BIT_SYM_ERR] = rx_report.sym_err;
        hdr_new[BIT_ETHERTYPE] = rx_report.len_type > ETHERTYPE_MIN
                                 && !rx_report.short_frame;
        hdr_new[BIT_OVERSIZE] = oversize;
        hdr_new[BIT_SHORT] = rx_report.short_frame;
        hdr_new[BIT_FCS] = rx_report.fcs_bad;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st             = st_ff;
        nxt_st.enq_pulse   = 1'b0;
        nxt_st.space_pulse = 1'b0;
        nxt_st.deliver     = 1'b0;
        nxt_st.discard     = 1'b0;
        nxt_st.rdata       = RST_WORD;

        // Register reads; unmapped offsets answer zero
        if (bus_rd) begin
            unique case (bus_addr)
                OFS_HDR_STATUS: begin
                    nxt_st.rdata = st_ff.hdr;
                end
                OFS_BYTE_COUNT: begin
                    nxt_st.rdata = {4'h0, st_ff.count};
                end
                OFS_TX_CMD: begin
                    nxt_st.rdata = {14'h0000, st_ff.monitor, st_ff.enqueue};
                end
                OFS_TX_FREE: begin
                    nxt_st.rdata = {3'h0, tx_free_bytes};
                end
                OFS_FRAME_CFG: begin
                    nxt_st.rdata = {15'h0000, st_ff.pass_bad};
                end
                OFS_SPACE_REQ: begin
                    nxt_st.rdata = {3'h0, st_ff.space_req};
                end
                default: begin
                    nxt_st.rdata = RST_WORD;
                end
            endcase
        end

        // Reading the count releases the slot, so a frame is read once
        // single read per frame
        if (rd_count) begin
            nxt_st.hdr   = RST_WORD;
            nxt_st.count = RST_COUNT;
        end

        // New frame taken only into an empty slot
        if (take) begin
            if (keep) begin
                nxt_st.hdr     = hdr_new;
                nxt_st.count   = rx_report.byte_total;
                nxt_st.deliver = 1'b1;
            end else begin
                nxt_st.discard = 1'b1;
            end
        end

        // Writes
        if (bus_wr && bus_addr == OFS_FRAME_CFG) begin
            nxt_st.pass_bad = bus_wdata[BIT_PASS_BAD];
        end
        if (bus_wr && bus_addr == OFS_SPACE_REQ) begin
            nxt_st.space_req = bus_wdata[12:0];
        end

        if (tx_done) begin
            nxt_st.enqueue = 1'b0;
        end
        // Set needs st_ff.enqueue clear, so a write in the tx_done cycle is lost
        // only bits 0 and 1 act
        if (wr_cmd && bus_wdata[BIT_ENQUEUE] && !st_ff.enqueue) begin
            nxt_st.enqueue   = 1'b1;
            nxt_st.enq_pulse = 1'b1;
        end

        if (st_ff.monitor && tx_free_bytes >= st_ff.space_req) begin
            nxt_st.monitor     = 1'b0;
            nxt_st.space_pulse = 1'b1;
        end
        if (wr_cmd && bus_wdata[BIT_MONITOR]) begin
            nxt_st.monitor = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign bus_rdata       = st_ff.rdata;
    assign rx_slot_full    = st_ff.hdr[BIT_VALID];
    assign rx_deliver      = st_ff.deliver;
    assign rx_discard      = st_ff.discard;
    assign tx_enqueue_req  = st_ff.enq_pulse;
    assign tx_enqueue_busy = st_ff.enqueue;
    assign space_event     = st_ff.space_pulse;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    a_tcp_flag_copy: assert property (
        take && keep |=> st_ff.hdr[BIT_TCP_BAD] == $past(rx_report.tcp_bad))
        else $error("tcp flag not captured");

    a_udp_flag_copy: assert property (
        take && keep |=> st_ff.hdr[BIT_UDP_BAD] == $past(rx_report.udp_bad))
        else $error("udp flag not captured");

    a_bcast_flag: assert property (
        take && keep |=> st_ff.hdr[BIT_BCAST] == $past(rx_report.bcast))
        else $error("broadcast flag wrong");

    a_mcast_has_bcast: assert property (
        st_ff.hdr[BIT_BCAST] |-> st_ff.hdr[BIT_MCAST])
        else $error("broadcast without multicast");

    a_mcast_flag: assert property (
        take && keep |=> st_ff.hdr[BIT_MCAST] == ($past(rx_report.mcast) || $past(rx_report.bcast)))
        else $error("multicast flag wrong");

    a_ucast_flag: assert property (
        take && keep |=> st_ff.hdr[BIT_UCAST] == $past(rx_report.ucast))
        else $error("unicast flag wrong");

    a_symbol_flag: assert property (
        take && keep |=> st_ff.hdr[BIT_SYM_ERR] == $past(rx_report.sym_err))
        else $error("symbol error flag wrong");

    a_type_flag: assert property (
        take && keep && rx_report.len_type > ETHERTYPE_MIN && !rx_report.short_frame
        |=> st_ff.hdr[BIT_ETHERTYPE])
        else $error("ethertype flag missing");

    a_type_clear: assert property (
        take && keep && rx_report.len_type <= ETHERTYPE_MIN |=> !st_ff.hdr[BIT_ETHERTYPE])
        else $error("length frame marked as type");

    a_runt_no_type: assert property (
        st_ff.hdr[BIT_SHORT] |-> !st_ff.hdr[BIT_ETHERTYPE])
        else $error("type flag on runt");

    a_oversize_flag: assert property (
        take && keep |=> st_ff.hdr[BIT_OVERSIZE] == ($past(rx_report.byte_total) > OVERSIZE_MAX))
        else $error("oversize flag wrong");

    a_full_count: assert property (
        take && keep |=> st_ff.count == $past(rx_report.byte_total))
        else $error("byte count truncated");

    a_bad_dropped: assert property (
        take && bad && !st_ff.pass_bad |=> rx_discard && !rx_slot_full)
        else $error("bad frame not dropped");

    a_bad_passed: assert property (
        take && bad && st_ff.pass_bad |=> rx_deliver && rx_slot_full)
        else $error("bad frame not passed");

    a_runt_flag: assert property (
        take && keep |=> st_ff.hdr[BIT_SHORT] == $past(rx_report.short_frame))
        else $error("runt flag wrong");

    a_fcs_flag: assert property (
        take && keep |=> st_ff.hdr[BIT_FCS] == $past(rx_report.fcs_bad))
        else $error("fcs flag wrong");

    a_deliver_pulse: assert property (
        rx_deliver |=> !rx_deliver)
        else $error("deliver longer than one cycle");

    a_count_reserved: assert property (
        $past(bus_rd) && $past(bus_addr) == OFS_BYTE_COUNT |-> bus_rdata[15:12] == 4'h0)
        else $error("count reserved bits set");

    a_hdr_reserved: assert property (
        st_ff.hdr[14:12] == 3'h0 && st_ff.hdr[9:8] == 2'h0)
        else $error("header reserved bits set");

    a_cmd_reserved: assert property (
        bus_rd && bus_addr == OFS_TX_CMD |=> bus_rdata[15:2] == 14'h0000)
        else $error("command reserved bits set");

    a_enqueue_start: assert property (
        wr_cmd && bus_wdata[BIT_ENQUEUE] && !tx_enqueue_busy
        |=> tx_enqueue_req && tx_enqueue_busy ##1 !tx_enqueue_req)
        else $error("enqueue not issued once");

    a_enqueue_clear: assert property (
        tx_done && !wr_cmd |=> !tx_enqueue_busy)
        else $error("enqueue bit not cleared");

    a_space_event: assert property (
        st_ff.monitor && tx_free_bytes >= st_ff.space_req && !wr_cmd
        |=> space_event && !st_ff.monitor)
        else $error("space event missing");

    a_monitor_clear: assert property (
        space_event |-> !st_ff.monitor || $past(wr_cmd))
        else $error("monitor not self-cleared");

    a_valid_only: assert property (
        rx_slot_full |-> st_ff.hdr[BIT_VALID] && $stable(st_ff.count) || $past(take))
        else $error("valid without frame");

    a_slot_release: assert property (
        rd_count && !take |=> !rx_slot_full)
        else $error("slot not released by count read");

    a_free_bytes: assert property (
        bus_rd && bus_addr == OFS_TX_FREE |=> bus_rdata == {3'h0, $past(tx_free_bytes)})
        else $error("free space read wrong");

    c_frame_kept: cover property (take && keep ##1 rx_deliver);
    c_frame_dropped: cover property (take && !keep ##1 rx_discard);
    c_enqueue_done: cover property (tx_enqueue_req ##[1:50] tx_done);
    c_space_seen: cover property (space_event);
    c_bad_passed: cover property (take && bad && keep ##1 rx_deliver);

endmodule

// File: include/rx_tx_pkg.sv
// Constants and carriers for the receive status and transmit queue block.
// Assumes byte addresses on a plain 16-bit register port.
package rx_tx_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_TX_FREE     = 8'h78;
    localparam logic [7:0] OFS_HDR_STATUS  = 8'h7C;
    localparam logic [7:0] OFS_BYTE_COUNT  = 8'h7E;
    localparam logic [7:0] OFS_TX_CMD      = 8'h80;
    localparam logic [7:0] OFS_FRAME_CFG   = 8'h90;
    localparam logic [7:0] OFS_SPACE_REQ   = 8'h9E;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_VALID     = 15;
    localparam int BIT_TCP_BAD   = 11;
    localparam int BIT_UDP_BAD   = 10;
    localparam int BIT_BCAST     = 7;
    localparam int BIT_MCAST     = 6;
    localparam int BIT_UCAST     = 5;
    localparam int BIT_SYM_ERR   = 4;
    localparam int BIT_ETHERTYPE = 3;
    localparam int BIT_OVERSIZE  = 2;
    localparam int BIT_SHORT     = 1;
    localparam int BIT_FCS       = 0;
    localparam int BIT_ENQUEUE   = 0;
    localparam int BIT_MONITOR   = 1;
    localparam int BIT_PASS_BAD  = 0;

    // ------------------------------------------------------------
    // Limits and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] ETHERTYPE_MIN = 16'd1500;
    localparam logic [11:0] OVERSIZE_MAX  = 12'd2000;
    localparam logic [15:0] RST_WORD      = 16'h0000;
    localparam logic [12:0] RST_SPACE     = 13'h0000;
    localparam logic [11:0] RST_COUNT     = 12'h000;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        tcp_bad;
        logic        udp_bad;
        logic        bcast;
        logic        mcast;
        logic        ucast;
        logic        sym_err;
        logic        short_frame;
        logic        fcs_bad;
        logic [15:0] len_type;
        logic [11:0] byte_total;
    } rx_report_type;

    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_type;

endpackage
